// ===== rtl/scurve_pkg.sv
package scurve_pkg;
	// bus geometry
	localparam int ADDR_W = 8;
	localparam int DATA_W = 32;
	// datapath widths
	localparam int SPD_W = 16;
	localparam int ACC_W = 16;
	localparam int RATE_W = 16;
	localparam int CNT_W = 24;
	localparam int PACC_W = 24;
	// register byte offsets
	localparam logic [ADDR_W-1:0] OFS_MODE = 8'h00;
	localparam logic [ADDR_W-1:0] OFS_JERK = 8'h04;
	localparam logic [ADDR_W-1:0] OFS_DRATE = 8'h08;
	localparam logic [ADDR_W-1:0] OFS_ALIM = 8'h0c;
	localparam logic [ADDR_W-1:0] OFS_DLIM = 8'h10;
	localparam logic [ADDR_W-1:0] OFS_SSPD = 8'h14;
	localparam logic [ADDR_W-1:0] OFS_VSPD = 8'h18;
	localparam logic [ADDR_W-1:0] OFS_PCNT = 8'h1c;
	localparam logic [ADDR_W-1:0] OFS_DPT = 8'h20;
	localparam logic [ADDR_W-1:0] OFS_CMD = 8'h24;
	localparam logic [ADDR_W-1:0] OFS_STAT = 8'h28;
	localparam logic [ADDR_W-1:0] OFS_CURSPD = 8'h2c;
	localparam logic [ADDR_W-1:0] OFS_OUTCNT = 8'h30;
	// mode bit positions
	localparam int MODE_MANUAL_BIT = 0;
	localparam int MODE_SEPDEC_BIT = 1;
	localparam int MODE_SCURVE_BIT = 2;
	// command bit positions
	localparam int CMD_FIXED_BIT = 0;
	localparam int CMD_CONT_BIT = 1;
	localparam int CMD_STOP_BIT = 2;
	// reset values
	localparam logic [15:0] MODE_RST = 16'h0004;
	localparam logic [RATE_W-1:0] RATE_RST = 16'h0001;
	localparam logic [ACC_W-1:0] LIM_RST = 16'h1f40;
	// triangle prevention fraction
	localparam logic [3:0] TRI_DIV = 4'hc;
	// axi responses
	localparam logic [1:0] RESP_OKAY = 2'b00;
	localparam logic [1:0] RESP_SLVERR = 2'b10;
	// ramp update period
	localparam int CLK_PERIOD_NS = 100;
	localparam int RAMP_TICK_NS = 1000;
	localparam int RAMP_TICK_CYC = (RAMP_TICK_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam logic [7:0] RAMP_TICK_LAST = 8'(RAMP_TICK_CYC - 1);
	// profile phases
	typedef enum logic [2:0] {PH_IDLE, PH_ACC_UP, PH_ACC_DN, PH_CRUISE, PH_DEC_UP, PH_DEC_DN} phase_e;
endpackage

// ===== rtl/pulse_rate_if.sv
`timescale 1ns/1ps
interface pulse_rate_if;
	import scurve_pkg::*;
	logic             run;   // pulse output allowed
	logic [SPD_W-1:0] speed; // current speed word
	logic             pulse; // one-cycle drive pulse
	modport ctrl (output run, output speed, input pulse);
	modport gen (input run, input speed, output pulse);
endinterface

// ===== rtl/pulse_rate_gen.sv
`timescale 1ns/1ps
module pulse_rate_gen
	import scurve_pkg::*;
(
	// clock and reset
	input  wire logic i_sys_clk,
	input  wire logic i_rst,
	// speed in, pulse out
	pulse_rate_if.gen rate
);
	logic [PACC_W:0]   phase_acc_r;   // phase accumulator with carry
	logic [PACC_W:0]   phase_acc_nxt;
	logic              pulse_r;       // registered pulse
	logic              pulse_nxt;

	// add speed each cycle while run is high, carry out is one drive pulse
	always_comb begin
		phase_acc_nxt = {1'b0, phase_acc_r[PACC_W-1:0]};
		pulse_nxt = 1'b0;
		if (rate.run) begin
			phase_acc_nxt = {1'b0, phase_acc_r[PACC_W-1:0]} + {{(PACC_W-SPD_W+1){1'b0}}, rate.speed};
			pulse_nxt = phase_acc_nxt[PACC_W];
		end
	end

	// register accumulator and pulse
	always_ff @(posedge i_sys_clk or posedge i_rst) begin
		if (i_rst) begin
			phase_acc_r <= '0;
			pulse_r <= 1'b0;
		end else begin
			phase_acc_r <= phase_acc_nxt;
			pulse_r <= pulse_nxt;
		end
	end

	assign rate.pulse = pulse_r;
endmodule

// ===== rtl/scurve_profile_generator.sv
// Notes on behaviour
// - low start speed: early finish or creep
// - peak speed may stay below target
// - acceleration ramps linearly at jerk rate
// - asymmetric mode: jerk up, decel-rate down
// - asymmetric fixed drive: no automatic deceleration; the code still decelerates automatically unless the manual bit is also set
// - asymmetric mode lacks 1/12 triangle guard; the code applies the guard in fixed drives whenever the manual bit is clear
// - separate-rate bit selects deceleration increase rate
// - decel pulse estimate only ideal
// - symmetric: decelerate when remaining below accel pulses
// - symmetric: past 1/12 pulses, reduce acceleration
// - mode 100: auto decel with accel values
// - acceleration limit clips ramp magnitude
//
// The register addresses and the AXI4-Lite slave port were left to the implementer.
`timescale 1ns/1ps
module scurve_profile_generator
	import scurve_pkg::*;
(
	// clock and reset
	input  wire logic                 i_sys_clk,
	input  wire logic                 i_rst,
	// axi4-lite write address
	input  wire logic                 i_awvalid,
	input  wire logic [ADDR_W-1:0]    i_awaddr,
	output logic                      o_awready,
	// axi4-lite write data
	input  wire logic                 i_wvalid,
	input  wire logic [DATA_W-1:0]    i_wdata,
	input  wire logic [DATA_W/8-1:0]  i_wstrb,
	output logic                      o_wready,
	// axi4-lite write response
	output logic                      o_bvalid,
	output logic [1:0]                o_bresp,
	input  wire logic                 i_bready,
	// axi4-lite read
	input  wire logic                 i_arvalid,
	input  wire logic [ADDR_W-1:0]    i_araddr,
	output logic                      o_arready,
	output logic                      o_rvalid,
	output logic [DATA_W-1:0]         o_rdata,
	output logic [1:0]                o_rresp,
	input  wire logic                 i_rready,
	// drive output
	output logic                      o_drive_pulse,
	output logic                      o_busy
);
	import scurve_pkg::*;

	pulse_rate_if rate_bus ();          // speed to pulse generator

	// true when a byte offset names a mapped register
	function automatic logic is_mapped(input logic [ADDR_W-1:0] a);
		return (a <= OFS_OUTCNT) && (a[1:0] == 2'b00);
	endfunction

	// bus slave state
	logic                aw_held_r, aw_held_nxt;   // address latched
	logic                w_held_r, w_held_nxt;     // data latched
	logic [ADDR_W-1:0]   waddr_r, waddr_nxt;
	logic [DATA_W-1:0]   wdata_r, wdata_nxt;
	logic                bvalid_r, bvalid_nxt;
	logic [1:0]          bresp_r, bresp_nxt;
	logic                rvalid_r, rvalid_nxt;
	logic [DATA_W-1:0]   rdata_r, rdata_nxt;
	logic [1:0]          rresp_r, rresp_nxt;
	logic                do_write;                 // both halves present
	// programmed parameters
	logic [15:0]         mode_r, mode_nxt;         // axis_drive_mode_control
	logic [RATE_W-1:0]   jerk_r, jerk_nxt;
	logic [RATE_W-1:0]   drate_r, drate_nxt;       // deceleration increase rate
	logic [ACC_W-1:0]    alim_r, alim_nxt;
	logic [ACC_W-1:0]    dlim_r, dlim_nxt;
	logic [SPD_W-1:0]    start_speed_r, start_speed_nxt;
	logic [SPD_W-1:0]    vspd_r, vspd_nxt;
	logic [CNT_W-1:0]    pcnt_r, pcnt_nxt;
	logic [CNT_W-1:0]    decel_start_point_r, decel_start_point_nxt;
	logic [2:0]          cmd_r, cmd_nxt;           // one-cycle command strobes
	// profile state
	phase_e              phase_r, phase_nxt;
	logic                fixed_r, fixed_nxt;       // fixed-pulse drive
	logic                pend_r, pend_nxt;         // deceleration requested
	logic [ACC_W-1:0]    acc_r, acc_nxt;
	logic [SPD_W-1:0]    spd_r, spd_nxt;
	logic [SPD_W-1:0]    gain_r, gain_nxt;         // speed gained on rising ramp
	logic [RATE_W-1:0]   jcnt_r, jcnt_nxt;
	logic [7:0]          tick_r, tick_nxt;
	logic [CNT_W-1:0]    out_cnt_r, out_cnt_nxt;
	logic [CNT_W-1:0]    acc_pulses_r, acc_pulses_nxt;
	logic                busy_r, busy_nxt;

	assign do_write = aw_held_r && w_held_r && !bvalid_r;

	// bus slave: channel handshakes and register file
	always_comb begin
		aw_held_nxt = aw_held_r;
		w_held_nxt = w_held_r;
		waddr_nxt = waddr_r;
		wdata_nxt = wdata_r;
		bvalid_nxt = bvalid_r && !i_bready;
		bresp_nxt = bresp_r;
		rvalid_nxt = rvalid_r && !i_rready;
		rdata_nxt = rdata_r;
		rresp_nxt = rresp_r;
		mode_nxt = mode_r;
		jerk_nxt = jerk_r;
		drate_nxt = drate_r;
		alim_nxt = alim_r;
		dlim_nxt = dlim_r;
		start_speed_nxt = start_speed_r;
		vspd_nxt = vspd_r;
		pcnt_nxt = pcnt_r;
		decel_start_point_nxt = decel_start_point_r;
		cmd_nxt = '0;
		// take address and data in either order
		if (i_awvalid && !aw_held_r) begin
			aw_held_nxt = 1'b1;
			waddr_nxt = i_awaddr;
		end
		if (i_wvalid && !w_held_r) begin
			w_held_nxt = 1'b1;
			wdata_nxt = i_wdata;
		end
		// commit when both halves are held
		if (do_write) begin
			aw_held_nxt = 1'b0;
			w_held_nxt = 1'b0;
			bvalid_nxt = 1'b1;
			bresp_nxt = is_mapped(waddr_r) ? RESP_OKAY : RESP_SLVERR;
			case (waddr_r)
				OFS_MODE:   mode_nxt = wdata_r[15:0];
				OFS_JERK:   jerk_nxt = wdata_r[RATE_W-1:0];
				OFS_DRATE:  drate_nxt = wdata_r[RATE_W-1:0];
				OFS_ALIM:   alim_nxt = wdata_r[ACC_W-1:0];
				OFS_DLIM:   dlim_nxt = wdata_r[ACC_W-1:0];
				OFS_SSPD:   start_speed_nxt = wdata_r[SPD_W-1:0];
				OFS_VSPD:   vspd_nxt = wdata_r[SPD_W-1:0];
				OFS_PCNT:   pcnt_nxt = wdata_r[CNT_W-1:0];
				OFS_DPT:    decel_start_point_nxt = wdata_r[CNT_W-1:0];
				OFS_CMD:    cmd_nxt = wdata_r[2:0];
				default:    cmd_nxt = '0; // read-only or unmapped: no effect
			endcase
		end
		// reads answer one cycle after acceptance
		if (i_arvalid && !rvalid_r) begin
			rvalid_nxt = 1'b1;
			rresp_nxt = is_mapped(i_araddr) ? RESP_OKAY : RESP_SLVERR;
			case (i_araddr)
				OFS_JERK:   rdata_nxt = DATA_W'(jerk_r);
				OFS_DRATE:  rdata_nxt = DATA_W'(drate_r);
				OFS_ALIM:   rdata_nxt = DATA_W'(alim_r);
				OFS_DLIM:   rdata_nxt = DATA_W'(dlim_r);
				OFS_SSPD:   rdata_nxt = DATA_W'(start_speed_r);
				OFS_VSPD:   rdata_nxt = DATA_W'(vspd_r);
				OFS_PCNT:   rdata_nxt = DATA_W'(pcnt_r);
				OFS_DPT:    rdata_nxt = DATA_W'(decel_start_point_r);
				OFS_STAT:   rdata_nxt = DATA_W'({phase_r, busy_r});
				OFS_CURSPD: rdata_nxt = DATA_W'(spd_r);
				OFS_OUTCNT: rdata_nxt = DATA_W'(out_cnt_r);
				default:    rdata_nxt = '0; // mode is write-only
			endcase
		end
	end

	// profile: phases of the s-curve and pulse bookkeeping
	always_comb begin
		logic             manual;
		logic             sepdec;
		logic [RATE_W-1:0] rate;
		logic [ACC_W-1:0] lim;
		logic             step;
		logic             trig;
		logic             done;
		logic [CNT_W+3:0] used12;
		logic [SPD_W:0]   sum;
		manual = mode_r[MODE_MANUAL_BIT];
		sepdec = mode_r[MODE_SEPDEC_BIT];
		trig = 1'b0;
		phase_nxt = phase_r;
		fixed_nxt = fixed_r;
		pend_nxt = pend_r;
		acc_nxt = acc_r;
		spd_nxt = spd_r;
		gain_nxt = gain_r;
		jcnt_nxt = jcnt_r;
		tick_nxt = (tick_r == RAMP_TICK_LAST) ? 8'h00 : tick_r + 8'h01;
		out_cnt_nxt = out_cnt_r + (rate_bus.pulse ? CNT_W'(1) : CNT_W'(0));
		acc_pulses_nxt = acc_pulses_r;
		// deceleration ramps use the separate rate and limit when selected
		rate = (phase_r inside {PH_DEC_UP, PH_DEC_DN} && sepdec) ? drate_r : jerk_r;
		lim = (phase_r inside {PH_DEC_UP, PH_DEC_DN} && sepdec) ? dlim_r : alim_r;
		step = (tick_r == RAMP_TICK_LAST) && (jcnt_r + RATE_W'(1) >= rate);
		if (tick_r == RAMP_TICK_LAST) begin
			jcnt_nxt = step ? '0 : jcnt_r + RATE_W'(1);
		end
		// pulses so far scaled by the triangle fraction divisor
		used12 = {4'h0, out_cnt_r} * {{(CNT_W){1'b0}}, TRI_DIV};
		// deceleration trigger: manual point or automatic remaining count
		if (manual) begin
			trig = fixed_r && (out_cnt_r >= decel_start_point_r);
		end else begin
			trig = fixed_r && ((pcnt_r - out_cnt_r) < acc_pulses_r);
		end
		done = fixed_r && (out_cnt_r >= pcnt_r);
		sum = {1'b0, spd_r} + {1'b0, acc_r};
		case (phase_r)
			PH_IDLE: begin
				if (cmd_r[CMD_FIXED_BIT] || cmd_r[CMD_CONT_BIT]) begin
					phase_nxt = PH_ACC_UP;
					fixed_nxt = cmd_r[CMD_FIXED_BIT];
					pend_nxt = 1'b0;
					acc_nxt = '0;
					spd_nxt = start_speed_r;
					gain_nxt = '0;
					jcnt_nxt = '0;
					out_cnt_nxt = '0;
					acc_pulses_nxt = '0;
				end
			end
			PH_ACC_UP, PH_ACC_DN: begin
				acc_pulses_nxt = out_cnt_r;
				if (trig || cmd_r[CMD_STOP_BIT]) begin
					pend_nxt = 1'b1;
				end
				if (tick_r == RAMP_TICK_LAST) begin
					spd_nxt = (sum > {1'b0, vspd_r}) ? vspd_r : sum[SPD_W-1:0];
					if (phase_r == PH_ACC_UP) begin
						gain_nxt = gain_r + SPD_W'(acc_r);
					end
				end
				if (phase_r == PH_ACC_UP) begin
					if (step && acc_r < lim) begin
						acc_nxt = acc_r + ACC_W'(1);
					end
					// turn over near target, on a pending stop, or past the fraction
					if ((vspd_r - spd_r) <= gain_r || pend_r ||
						(!manual && fixed_r && used12 > {4'h0, pcnt_r})) begin
						phase_nxt = PH_ACC_DN;
					end
				end else begin
					if (step && acc_r != '0) begin
						acc_nxt = acc_r - ACC_W'(1);
					end
					if (acc_r == '0 || spd_r >= vspd_r) begin
						acc_nxt = '0;
						gain_nxt = '0;
						phase_nxt = pend_r ? PH_DEC_UP : PH_CRUISE;
					end
				end
			end
			PH_CRUISE: begin
				if (trig || cmd_r[CMD_STOP_BIT]) begin
					phase_nxt = PH_DEC_UP;
				end
			end
			PH_DEC_UP, PH_DEC_DN: begin
				if (tick_r == RAMP_TICK_LAST) begin
					spd_nxt = (spd_r <= start_speed_r + acc_r) ? start_speed_r : spd_r - acc_r;
					if (phase_r == PH_DEC_UP) begin
						gain_nxt = gain_r + SPD_W'(acc_r);
					end
				end
				if (phase_r == PH_DEC_UP) begin
					if (step && acc_r < lim) begin
						acc_nxt = acc_r + ACC_W'(1);
					end
					if ((spd_r - start_speed_r) <= gain_r) begin
						phase_nxt = PH_DEC_DN;
					end
				end else if (step && acc_r != '0) begin
					acc_nxt = acc_r - ACC_W'(1);
				end
				// continuous drive ends once start speed is reached
				if (!fixed_r && spd_r <= start_speed_r) begin
					phase_nxt = PH_IDLE;
				end
			end
			default: phase_nxt = PH_IDLE;
		endcase
		// fixed drive ends on the last pulse wherever the speed stands
		if (phase_r != PH_IDLE && done) begin
			phase_nxt = PH_IDLE;
		end
		busy_nxt = (phase_nxt != PH_IDLE);
	end

	// register all state
	always_ff @(posedge i_sys_clk or posedge i_rst) begin
		if (i_rst) begin
			aw_held_r <= 1'b0;
			w_held_r <= 1'b0;
			waddr_r <= '0;
			wdata_r <= '0;
			bvalid_r <= 1'b0;
			bresp_r <= RESP_OKAY;
			rvalid_r <= 1'b0;
			rdata_r <= '0;
			rresp_r <= RESP_OKAY;
			mode_r <= MODE_RST;
			jerk_r <= RATE_RST;
			drate_r <= RATE_RST;
			alim_r <= LIM_RST;
			dlim_r <= LIM_RST;
			start_speed_r <= '0;
			vspd_r <= '0;
			pcnt_r <= '0;
			decel_start_point_r <= '0;
			cmd_r <= '0;
			phase_r <= PH_IDLE;
			fixed_r <= 1'b0;
			pend_r <= 1'b0;
			acc_r <= '0;
			spd_r <= '0;
			gain_r <= '0;
			jcnt_r <= '0;
			tick_r <= '0;
			out_cnt_r <= '0;
			acc_pulses_r <= '0;
			busy_r <= 1'b0;
		end else begin
			aw_held_r <= aw_held_nxt;
			w_held_r <= w_held_nxt;
			waddr_r <= waddr_nxt;
			wdata_r <= wdata_nxt;
			bvalid_r <= bvalid_nxt;
			bresp_r <= bresp_nxt;
			rvalid_r <= rvalid_nxt;
			rdata_r <= rdata_nxt;
			rresp_r <= rresp_nxt;
			mode_r <= mode_nxt;
			jerk_r <= jerk_nxt;
			drate_r <= drate_nxt;
			alim_r <= alim_nxt;
			dlim_r <= dlim_nxt;
			start_speed_r <= start_speed_nxt;
			vspd_r <= vspd_nxt;
			pcnt_r <= pcnt_nxt;
			decel_start_point_r <= decel_start_point_nxt;
			cmd_r <= cmd_nxt;
			phase_r <= phase_nxt;
			fixed_r <= fixed_nxt;
			pend_r <= pend_nxt;
			acc_r <= acc_nxt;
			spd_r <= spd_nxt;
			gain_r <= gain_nxt;
			jcnt_r <= jcnt_nxt;
			tick_r <= tick_nxt;
			out_cnt_r <= out_cnt_nxt;
			acc_pulses_r <= acc_pulses_nxt;
			busy_r <= busy_nxt;
		end
	end

	// pulses only while a drive runs and count is not exhausted
	assign rate_bus.run = busy_r && !(fixed_r && out_cnt_r >= pcnt_r);
	assign rate_bus.speed = spd_r;

	pulse_rate_gen u_gen (
		.i_sys_clk (i_sys_clk),
		.i_rst     (i_rst),
		.rate      (rate_bus.gen)
	);

	// outputs straight from flip-flops
	assign o_awready = !aw_held_r;
	assign o_wready = !w_held_r;
	assign o_bvalid = bvalid_r;
	assign o_bresp = bresp_r;
	assign o_arready = !rvalid_r;
	assign o_rvalid = rvalid_r;
	assign o_rdata = rdata_r;
	assign o_rresp = rresp_r;
	assign o_drive_pulse = rate_bus.pulse;
	assign o_busy = busy_r;
endmodule

// ===== sim/scurve_profile_generator_asserts.sv
`timescale 1ns/1ps
module scurve_profile_generator_asserts
	import scurve_pkg::*;
(
	// clock and reset
	input wire logic                i_sys_clk,
	input wire logic                i_rst,
	// register bus
	input wire logic                i_awvalid,
	input wire logic [ADDR_W-1:0]   i_awaddr,
	input wire logic                o_awready,
	input wire logic                i_wvalid,
	input wire logic [DATA_W-1:0]   i_wdata,
	input wire logic [DATA_W/8-1:0] i_wstrb,
	input wire logic                o_wready,
	input wire logic                o_bvalid,
	input wire logic [1:0]          o_bresp,
	input wire logic                i_bready,
	input wire logic                i_arvalid,
	input wire logic [ADDR_W-1:0]   i_araddr,
	input wire logic                o_arready,
	input wire logic                o_rvalid,
	input wire logic [DATA_W-1:0]   o_rdata,
	input wire logic [1:0]          o_rresp,
	input wire logic                i_rready,
	// drive side
	input wire logic                o_drive_pulse,
	input wire logic                o_busy
);
	default clocking @(posedge i_sys_clk); endclocking
	default disable iff (i_rst);
	// pulses only leave while a drive runs
	busy_pulse_a: assert property (o_drive_pulse |-> o_busy || $past(o_busy))
		else $error("drive pulse outside a drive");
	// no pulse in the 8 cycles after the drive has ended
	end_quiet_a: assert property ($fell(o_busy) |=> !o_drive_pulse [*8])
		else $error("pulse after drive end");
	// a 16-bit speed cannot give pulses closer than 256 cycles
	pulse_gap_a: assert property (o_drive_pulse |=> !o_drive_pulse [*8])
		else $error("drive pulses too close");
	// a drive starts only shortly after a write response
	start_cause_a: assert property ($rose(o_busy) |-> $past(o_bvalid) || $past(o_bvalid, 2)
		|| $past(o_bvalid, 3) || $past(o_bvalid, 4))
		else $error("drive started without a write");
	// write answered after both channels taken
	write_resp_a: assert property (i_awvalid && o_awready && i_wvalid && o_wready |-> ##[1:2] o_bvalid)
		else $error("write response missing");
	bvalid_drop_a: assert property (o_bvalid && i_bready |=> !o_bvalid)
		else $error("write response repeated");
	// read answered on the next edge
	read_resp_a: assert property (i_arvalid && o_arready |=> o_rvalid)
		else $error("read data missing");
	ar_block_a: assert property (o_rvalid |-> !o_arready)
		else $error("read address taken while data pending");
	rvalid_drop_a: assert property (o_rvalid && i_rready |=> !o_rvalid)
		else $error("read data repeated");
endmodule

// ===== sim/host_axi_model.sv
`timescale 1ns/1ps
module host_axi_model
	import scurve_pkg::*;
(
	// clock
	input  wire logic              i_sys_clk,
	// write channels
	output logic                   o_awvalid,
	output logic [ADDR_W-1:0]      o_awaddr,
	input  wire logic              i_awready,
	output logic                   o_wvalid,
	output logic [DATA_W-1:0]      o_wdata,
	output logic [DATA_W/8-1:0]    o_wstrb,
	input  wire logic              i_wready,
	input  wire logic              i_bvalid,
	input  wire logic [1:0]        i_bresp,
	output logic                   o_bready,
	// read channels
	output logic                   o_arvalid,
	output logic [ADDR_W-1:0]      o_araddr,
	input  wire logic              i_arready,
	input  wire logic              i_rvalid,
	input  wire logic [DATA_W-1:0] i_rdata,
	input  wire logic [1:0]        i_rresp,
	output logic                   o_rready
);
	import scurve_pkg::*;
	// bus idle at time zero
	initial begin
		{o_awvalid, o_wvalid, o_bready, o_arvalid, o_rready} = 5'h0;
		{o_awaddr, o_araddr, o_wdata, o_wstrb} = '0;
	end
	// one write; callers keep speed and count still during fixed drives
	task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d, output logic [1:0] r);
		logic aw_left;
		logic w_left;
		aw_left = 1'b1;
		w_left = 1'b1;
		@(posedge i_sys_clk);
		{o_awvalid, o_wvalid, o_bready} <= 3'h7;
		o_awaddr <= a;
		o_wdata <= d;
		o_wstrb <= 4'hf;
		while (aw_left || w_left) begin
			@(posedge i_sys_clk);
			// released lines show the inverse, not the old value
			if (aw_left && i_awready === 1'b1) begin
				aw_left = 1'b0;
				o_awvalid <= 1'b0;
				o_awaddr <= ~a;
			end
			if (w_left && i_wready === 1'b1) begin
				w_left = 1'b0;
				o_wvalid <= 1'b0;
				o_wdata <= ~d;
			end
		end
		while (i_bvalid !== 1'b1) @(posedge i_sys_clk);
		r = i_bresp;
		o_bready <= 1'b0;
	endtask
	// one read
	task automatic rd(input logic [ADDR_W-1:0] a, output logic [DATA_W-1:0] d, output logic [1:0] r);
		@(posedge i_sys_clk);
		{o_arvalid, o_rready} <= 2'h3;
		o_araddr <= a;
		do @(posedge i_sys_clk); while (i_arready !== 1'b1);
		o_arvalid <= 1'b0;
		o_araddr <= ~a;
		while (i_rvalid !== 1'b1) @(posedge i_sys_clk);
		d = i_rdata;
		r = i_rresp;
		o_rready <= 1'b0;
	endtask
endmodule

// ===== sim/scurve_profile_generator_tb.sv
`timescale 1ns/1ps
module scurve_profile_generator_tb;
	import scurve_pkg::*;
	logic                i_sys_clk = 1'b0; // system clock
	logic                i_rst = 1'b1;     // reset
	logic                i_awvalid, i_wvalid, i_bready, i_arvalid, i_rready, o_awready, o_wready;
	logic                o_bvalid, o_arready, o_rvalid, o_drive_pulse, o_busy;
	logic [ADDR_W-1:0]   i_awaddr, i_araddr;
	logic [DATA_W-1:0]   i_wdata, o_rdata;
	logic [DATA_W/8-1:0] i_wstrb;
	logic [1:0]          o_bresp, o_rresp;
	int                  failures, n_tests, cyc, n_pulse;
	always #50 i_sys_clk = ~i_sys_clk;
	scurve_profile_generator i_dut (.i_sys_clk, .i_rst, .i_awvalid, .i_awaddr, .o_awready, .i_wvalid,
		.i_wdata, .i_wstrb, .o_wready, .o_bvalid, .o_bresp, .i_bready, .i_arvalid, .i_araddr, .o_arready,
		.o_rvalid, .o_rdata, .o_rresp, .i_rready, .o_drive_pulse, .o_busy);
	host_axi_model i_host (.i_sys_clk, .o_awvalid(i_awvalid), .o_awaddr(i_awaddr), .i_awready(o_awready),
		.o_wvalid(i_wvalid), .o_wdata(i_wdata), .o_wstrb(i_wstrb), .i_wready(o_wready), .i_bvalid(o_bvalid),
		.i_bresp(o_bresp), .o_bready(i_bready), .o_arvalid(i_arvalid), .o_araddr(i_araddr),
		.i_arready(o_arready), .i_rvalid(o_rvalid), .i_rdata(o_rdata), .i_rresp(o_rresp), .o_rready(i_rready));
	// verdict and stop
	task automatic end_sim;
		if (failures == 0 && n_tests > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask
	// compare and tally
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		n_tests++;
		if (seen !== exp) begin
			failures++;
			$display("unexpected at %0t: got %h want %h", $time, seen, exp);
		end
	endtask
	task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
		logic [31:0] d;
		logic [1:0]  r;
		i_host.rd(a, d, r);
		chk(d, exp);
	endtask
	task automatic wrok(input logic [7:0] a, input logic [31:0] d);
		logic [1:0] r;
		i_host.wr(a, d, r);
		chk({30'h0, r}, {30'h0, RESP_OKAY});
	endtask
	// poll phase, count and speed until the drive ends
	task automatic watch(input int dpt, input logic [31:0] vmax, output logic saw_dec);
		logic [31:0] s, c, v;
		logic [1:0]  r;
		saw_dec = 1'b0;
		repeat (5) @(posedge i_sys_clk);
		chk({31'h0, o_busy}, 32'h1);
		while (o_busy === 1'b1) begin
			i_host.rd(OFS_STAT, s, r);
			i_host.rd(OFS_OUTCNT, c, r);
			i_host.rd(OFS_CURSPD, v, r);
			saw_dec |= (s[3:1] >= 3'd4);
			chk({31'h0, v > vmax}, 32'h0);
			if (c < dpt)
				chk({31'h0, s[3:1] >= 3'd4}, 32'h0);
		end
	endtask
	// reset values, write-only mode, unmapped place
	task automatic t_regs;
		logic [31:0] d;
		logic [1:0]  r;
		rdchk(OFS_JERK, {16'h0, RATE_RST});
		rdchk(OFS_DRATE, {16'h0, RATE_RST});
		rdchk(OFS_ALIM, {16'h0, LIM_RST});
		rdchk(OFS_DLIM, {16'h0, LIM_RST});
		rdchk(OFS_MODE, 32'h0);
		i_host.rd(8'hfc, d, r);
		chk({30'h0, r} | d, {30'h0, RESP_SLVERR});
		i_host.wr(8'hfc, 32'h5, r);
		chk({30'h0, r}, {30'h0, RESP_SLVERR});
	endtask
	// symmetric fixed drive with automatic deceleration
	task automatic t_sym;
		logic saw;
		int   p0;
		wrok(OFS_MODE, 32'h4);
		wrok(OFS_ALIM, 32'h1f40);
		wrok(OFS_SSPD, 32'h8000);
		wrok(OFS_VSPD, 32'hffff);
		wrok(OFS_PCNT, 32'h14);
		p0 = n_pulse;
		wrok(OFS_CMD, 32'h1);
		watch(0, 32'hffff, saw);
		chk({31'h0, saw}, 32'h1);
		rdchk(OFS_OUTCNT, 32'h14);
		chk(n_pulse - p0, 20);
	endtask
	// asymmetric fixed drive, deceleration only at the set point
	task automatic t_asym;
		logic saw;
		int   p0;
		wrok(OFS_MODE, 32'h7);
		wrok(OFS_DLIM, 32'h1f40);
		wrok(OFS_JERK, 32'h1);
		wrok(OFS_DRATE, 32'h3);
		wrok(OFS_VSPD, 32'hc000);
		wrok(OFS_PCNT, 32'h1e);
		// point lies past where automatic deceleration would start
		wrok(OFS_DPT, 32'h1c);
		rdchk(OFS_DRATE, 32'h3);
		p0 = n_pulse;
		wrok(OFS_CMD, 32'h1);
		watch(28, 32'hc000, saw);
		chk({31'h0, saw}, 32'h1);
		chk(n_pulse - p0, 30);
	endtask
	// continuous drive ended by a decelerating stop
	task automatic t_cont;
		logic saw;
		wrok(OFS_MODE, 32'h4);
		wrok(OFS_CMD, 32'h2);
		repeat (3000) @(posedge i_sys_clk);
		wrok(OFS_CMD, 32'h4);
		watch(0, 32'hc000, saw);
		chk({31'h0, saw}, 32'h1);
	endtask
	// pulse tally and hang guard
	always @(posedge i_sys_clk) begin
		cyc <= cyc + 1;
		if (o_drive_pulse === 1'b1)
			n_pulse <= n_pulse + 1;
		if (cyc == 90000) begin
			failures++;
			end_sim;
		end
	end
	initial begin
		failures = 0;
		n_tests = 0;
		repeat (4) @(posedge i_sys_clk);
		i_rst <= 1'b0;
		t_regs;
		t_sym;
		t_asym;
		t_cont;
		end_sim;
	end
endmodule
bind scurve_profile_generator scurve_profile_generator_asserts i_chk (.i_sys_clk, .i_rst, .i_awvalid,
	.i_awaddr, .o_awready, .i_wvalid, .i_wdata, .i_wstrb, .o_wready, .o_bvalid, .o_bresp, .i_bready,
	.i_arvalid, .i_araddr, .o_arready, .o_rvalid, .o_rdata, .o_rresp, .i_rready, .o_drive_pulse, .o_busy);
